// file: rtl/rcar_pkg.sv
// Package: register map, field layout and timing constants of the timer/alarm register block
package rcar_pkg;
  // Byte addresses (printed offsets are not all multiples of four, so index * 4)
  localparam logic [3:0] IDX_WIN0 = 4'h0;
  localparam logic [3:0] IDX_WIN1 = 4'h1;
  localparam logic [3:0] IDX_WIN2 = 4'h2;
  localparam logic [3:0] IDX_WIN3 = 4'h3;
  localparam logic [3:0] IDX_CTRL = 4'h4;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h5;
  localparam logic [3:0] IDX_OSC_CFG = 4'h6;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h7;
  localparam logic [3:0] IDX_ALARM_VALUE_BYTE0 = 4'h8;
  localparam logic [3:0] IDX_ALARM_VALUE_BYTE1 = 4'h9;
  localparam logic [3:0] IDX_ALARM_VALUE_BYTE2 = 4'hA;
  localparam logic [3:0] IDX_ALARM_VALUE_BYTE3 = 4'hB;
  localparam int ADDR_W = 6;
  // Oscillator configuration fields
  localparam int OSC_STEP_EN_BIT = 7;
  localparam int OSC_READY_BIT = 6;
  localparam int OSC_TARGET_MSB = 3;
  localparam logic [3:0] OSC_TARGET_RST = 4'h8;
  localparam logic [3:0] OSC_APPLIED_RST = 4'h0;
  // Control register fields
  localparam int CTRL_SNAP_BIT = 0;
  localparam int CTRL_LOAD_BIT = 1;
  localparam int CTRL_ALARM_EN_BIT = 2;
  // Interrupt status / mask fields
  localparam int IRQ_ALARM_BIT = 0;
  localparam int IRQ_LOAD_DONE_BIT = 1;
  localparam int IRQ_SNAP_DONE_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // Timing: timer tick and capacitance step period
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_HZ = 32_768;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int STEP_US = 100;
  localparam int STEP_CYCLES = (CLK_HZ / 1_000_000) * STEP_US;
  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Transfer sequencer states
  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_LOAD = 2'b01,
    XFER_SNAP = 2'b11
  } rcar_xfer_e;
endpackage

// file: rtl/rcar_top.sv
// Timer capture window, alarm compare and load-capacitance stepping behind AXI4-Lite
// Functional notes
// [R1] Step-enable bit makes capacitance walk toward target
// [R2] Ready flag high when applied equals target
// [R3] Oscillator config bits 5:4 read zero
// [R4] Bits 3:0 hold target capacitance, reset varies; here reset loads 8
// [R5] Four window bytes form 32-bit timer window
// [R6] Load or snapshot only when go bits written
// [R7] Window little-endian, byte 0 holds bits 7:0
// [R8] Four alarm bytes hold 32-bit compare value
// [R9] Alarm value little-endian, byte 0 lowest
// [R10] Software disables alarm before changing alarm bytes
// [R11] Load go bit self-clears when load completes
// [R12] Snapshot go bit self-clears when copy completes
// [R13] Enabled alarm flags when timer equals alarm
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module rcar_top import rcar_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic [3:0] load_cap_applied,
  output logic alarm_match
);

  // Register state
  logic [7:0] win [4]; // Capture window bytes, little-endian
  logic [7:0] alarm [4]; // Alarm compare bytes, little-endian
  logic auto_cap_step_en; // Capacitance stepping enable
  logic [3:0] load_cap_target; // Programmed load capacitance
  logic timer_load_go; // Load request, self-clearing
  logic timer_snapshot_go; // Snapshot request, self-clearing
  logic alarm_enable_bit; // Alarm compare enable
  logic [IRQ_W-1:0] irq_status; // Sticky event bits
  logic [IRQ_W-1:0] irq_mask; // Event enables
  logic [31:0] timer; // Free-running timer
  logic [15:0] tick_cnt; // Timer tick divider
  logic [15:0] step_cnt; // Capacitance step divider
  rcar_xfer_e xfer; // Transfer sequencer
  logic [IRQ_W-1:0] evt; // Event pulses this cycle
  // Write channel holding
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire; // Both halves present, response slot free
  logic [3:0] wr_idx;
  logic wr_ok;
  logic rd_fire;
  logic [3:0] rd_idx;
  logic [31:0] rd_val;
  logic rd_ok;
  logic status_read; // Read of status clears it
  logic tick; // One-cycle timer tick
  logic step; // One-cycle step enable
  logic [31:0] win_word;
  logic [31:0] alarm_word;
  assign win_word = {win[3], win[2], win[1], win[0]}; // [R5] [R7]
  assign alarm_word = {alarm[3], alarm[2], alarm[1], alarm[0]}; // [R8] [R9]
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = aw_addr[5:2];
  assign wr_ok = (aw_addr[1:0] == 2'h0) && (wr_idx <= IDX_ALARM_VALUE_BYTE3);
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[5:2];
  assign rd_ok = (s_axi_araddr[1:0] == 2'h0) && (rd_idx <= IDX_ALARM_VALUE_BYTE3);
  assign status_read = rd_fire && rd_ok && (rd_idx == IDX_IRQ_STATUS);
  // Address channel: accept when no address is held
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_held <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      // Ready registered, low while one is held
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
    end
  end

  // Data channel: taken independently of address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      if (wr_fire) begin
        w_held <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
    end
  end

  // Write response
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read address ready: one read outstanding
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  // Read data mux; narrow registers sit in low bits
  always_comb begin
    rd_val = 32'h0000_0000;
    case (rd_idx)
      IDX_WIN0: rd_val = {24'h0, win[0]};
      IDX_WIN1: rd_val = {24'h0, win[1]};
      IDX_WIN2: rd_val = {24'h0, win[2]};
      IDX_WIN3: rd_val = {24'h0, win[3]};
      IDX_CTRL: rd_val = {29'h0, alarm_enable_bit, timer_load_go, timer_snapshot_go};
      IDX_IRQ_STATUS: rd_val = {29'h0, irq_status};
      IDX_OSC_CFG: rd_val = {24'h0, auto_cap_step_en, (load_cap_applied == load_cap_target), 2'b00,
        load_cap_target}; // [R2] [R3]
      IDX_IRQ_MASK: rd_val = {29'h0, irq_mask};
      IDX_ALARM_VALUE_BYTE0: rd_val = {24'h0, alarm[0]};
      IDX_ALARM_VALUE_BYTE1: rd_val = {24'h0, alarm[1]};
      IDX_ALARM_VALUE_BYTE2: rd_val = {24'h0, alarm[2]};
      IDX_ALARM_VALUE_BYTE3: rd_val = {24'h0, alarm[3]};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Read response
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_val : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Window bytes: software writes, snapshot overwrites all four
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      win <= '{default: 8'h00};
    end else if (xfer == XFER_SNAP) begin
      for (int i = 0; i < 4; i++) begin
        win[i] <= timer[8*i +: 8]; // [R6] [R7]
      end
    end else if (wr_fire && wr_ok && w_strb[0] && (wr_idx <= IDX_WIN3)) begin
      win[wr_idx[1:0]] <= w_data[7:0]; // [R5]
    end
  end

  // Alarm bytes; software is expected to disable the alarm first [R10]
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alarm <= '{default: 8'h00};
    end else if (wr_fire && wr_ok && w_strb[0] && (wr_idx >= IDX_ALARM_VALUE_BYTE0)) begin
      alarm[wr_idx[1:0]] <= w_data[7:0]; // [R8] [R9]
    end
  end

  // Oscillator configuration: only bits 7 and 3:0 are stored [R3]
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      auto_cap_step_en <= 1'b0;
      load_cap_target <= OSC_TARGET_RST; // [R4]
    end else if (wr_fire && wr_ok && w_strb[0] && (wr_idx == IDX_OSC_CFG)) begin
      auto_cap_step_en <= w_data[OSC_STEP_EN_BIT]; // [R1]
      load_cap_target <= w_data[OSC_TARGET_MSB:0]; // [R4]
    end
  end

  // Control bits; go bits cleared by hardware when the transfer ends
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_load_go <= 1'b0;
      timer_snapshot_go <= 1'b0;
      alarm_enable_bit <= 1'b0;
    end else begin
      if (wr_fire && wr_ok && w_strb[0] && (wr_idx == IDX_CTRL)) begin
        alarm_enable_bit <= w_data[CTRL_ALARM_EN_BIT];
        // Writing 0 does not cancel a pending request
        if (w_data[CTRL_LOAD_BIT]) begin
          timer_load_go <= 1'b1; // [R11]
        end
        if (w_data[CTRL_SNAP_BIT]) begin
          timer_snapshot_go <= 1'b1; // [R12]
        end
      end
      if (xfer == XFER_LOAD) begin
        timer_load_go <= 1'b0; // [R11]
      end
      if (xfer == XFER_SNAP) begin
        timer_snapshot_go <= 1'b0; // [R12]
      end
    end
  end

  // Sequencer: one transfer cycle per request, load before snapshot
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xfer <= XFER_IDLE;
    end else begin
      case (xfer)
        XFER_IDLE: begin
          if (timer_load_go) begin
            xfer <= XFER_LOAD; // [R6]
          end else if (timer_snapshot_go) begin
            xfer <= XFER_SNAP; // [R6]
          end
        end
        default: xfer <= XFER_IDLE;
      endcase
    end
  end

  // Timer: ticks at the divided rate, loaded from window on request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick <= 1'b0;
      timer <= 32'h0000_0000;
    end else begin
      tick <= (tick_cnt == 16'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
      if (xfer == XFER_LOAD) begin
        timer <= win_word; // [R6] [R7]
      end else if (tick) begin
        timer <= timer + 32'h0000_0001;
      end
    end
  end

  // Capacitance stepping: one step per period toward target
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      step_cnt <= '0;
      step <= 1'b0;
      load_cap_applied <= OSC_APPLIED_RST;
    end else begin
      step <= (step_cnt == 16'(STEP_CYCLES - 1));
      step_cnt <= (step_cnt == 16'(STEP_CYCLES - 1)) ? 16'h0000 : step_cnt + 16'h0001;
      // Disabled stepping freezes the applied value
      if (step && auto_cap_step_en) begin
        if (load_cap_applied < load_cap_target) begin
          load_cap_applied <= load_cap_applied + 4'h1; // [R1]
        end else if (load_cap_applied > load_cap_target) begin
          load_cap_applied <= load_cap_applied - 4'h1; // [R1]
        end
      end
    end
  end

  // Event pulses
  always_comb begin
    evt = '0;
    evt[IRQ_ALARM_BIT] = alarm_enable_bit && (timer == alarm_word) && !alarm_match; // [R13]
    evt[IRQ_LOAD_DONE_BIT] = (xfer == XFER_LOAD);
    evt[IRQ_SNAP_DONE_BIT] = (xfer == XFER_SNAP);
  end

  // Match level, so a long equal stretch flags once
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alarm_match <= 1'b0;
    end else begin
      alarm_match <= alarm_enable_bit && (timer == alarm_word); // [R13]
    end
  end

  // Sticky status: set wins over read-clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (status_read ? '0 : irq_status) | evt;
    end
  end

  // Mask register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_fire && wr_ok && w_strb[0] && (wr_idx == IDX_IRQ_MASK)) begin
      irq_mask <= w_data[IRQ_W-1:0];
    end
  end

  // Interrupt output registered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status_read ? '0 : irq_status) | evt) & irq_mask);
    end
  end

endmodule

// file: tb/rcar_asserts.sv
// Checker: port-level timing rules of the timer/alarm register block
`timescale 1ns/1ps
module rcar_asserts import rcar_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic [3:0] load_cap_applied,
  input wire logic alarm_match
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Both write halves taken at one edge
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Read address taken
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_both |=> ##1 s_axi_bvalid) else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready not a pulse");
  rd_err_a: assert property (rd_taken ##0 s_axi_araddr[5:2] > IDX_ALARM_VALUE_BYTE3 |=> s_axi_rvalid &&
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  rd_ok_a: assert property (rd_taken ##0 s_axi_araddr[5:2] <= IDX_ALARM_VALUE_BYTE3 |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  osc_zero_a: assert property (rd_taken ##0 s_axi_araddr == {IDX_OSC_CFG, 2'h0} |=>
    s_axi_rdata[5:4] == 2'h0) else $error("unused bits not zero");
  cap_step_a: assert property ($changed(load_cap_applied) |->
    load_cap_applied == $past(load_cap_applied) + 4'h1 || load_cap_applied == $past(load_cap_applied) - 4'h1)
    else $error("capacitance jumped");
  cap_pace_a: assert property ($changed(load_cap_applied) |=> $stable(load_cap_applied)[*8])
    else $error("capacitance stepped too fast");
  reset_out_a: assert property (disable iff (1'b0) !rst_n |=> !irq && !alarm_match &&
    load_cap_applied == 4'h0 && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not cleared by reset");
endmodule
bind rcar_top rcar_asserts u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .irq(irq),
  .load_cap_applied(load_cap_applied),
  .alarm_match(alarm_match)
);

// file: tb/rtc_capture_alarm_regs_tb.sv
// Testbench: register traffic, timer transfers, stepping and alarm of the timer/alarm block
`timescale 1ns/1ps
module rtc_capture_alarm_regs_tb import rcar_pkg::*; ;
  logic clock = 1'b0, rst_n = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d, v, w;
  logic [3:0] s_axi_wstrb = 4'hF, load_cap_applied;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, alarm_match;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] mdl [12] = '{default: 8'h00}; // Expected contents of the window and alarm bytes
  int error_cnt = 0, n_checks = 0, cyc = 0, seed = 32'h78f6f0b0;
  rcar_top dut (
    .clock(clock),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .irq(irq),
    .load_cap_applied(load_cap_applied),
    .alarm_match(alarm_match)
  );
  always #12.5 clock = ~clock;
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask
  // One write; junk above bit 7 must be ignored
  task automatic wr(input logic [3:0] i, input logic [7:0] b);
    @(posedge clock);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'($random(seed)), b};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($random(seed));
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      // Late ready makes the response stall, so the hold check has work
      if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, (i > IDX_ALARM_VALUE_BYTE3) ? RESP_SLVERR : RESP_OKAY);
    if (i <= IDX_ALARM_VALUE_BYTE3 && (i < 4'h4 || i > 4'h7)) mdl[i] = b;
  endtask
  // One read into d and r
  task automatic rd(input logic [3:0] i);
    @(posedge clock);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($random(seed));
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      // Late ready makes read data stand for an extra cycle
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Read against the model
  task automatic rdm(input logic [3:0] i);
    rd(i);
    chk(d, {24'h0, mdl[i]});
  endtask
  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, sized well above the stepping waits
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) if (i < 4 || i > 7) rdm(4'(i));
    rd(IDX_OSC_CFG);
    chk(d, 32'h08);
    $display("Test reset done");
    // Stepping on toward 3, junk in the unused bits
    wr(IDX_OSC_CFG, 8'hB3);
    rd(IDX_OSC_CFG);
    chk(d, 32'h83);
    for (int k = 0; k < 20000 && load_cap_applied !== 4'h3; k++) @(posedge clock);
    chk(load_cap_applied, 32'h3);
    rd(IDX_OSC_CFG);
    chk(d, 32'hC3);
    // Stepping off: applied must freeze away from target
    wr(IDX_OSC_CFG, 8'h05);
    repeat (9000) @(posedge clock);
    chk(load_cap_applied, 32'h3);
    rd(IDX_OSC_CFG);
    chk(d, 32'h05);
    $display("Test stepping done");
    v = $random(seed);
    for (int i = 0; i < 4; i++) wr(4'(i), v[8*i +: 8]);
    wr(IDX_CTRL, 8'h02);
    rd(IDX_CTRL);
    chk(d[1:0], 32'h0);
    for (int i = 0; i < 4; i++) rdm(4'(i));
    wr(IDX_CTRL, 8'h01);
    rd(IDX_CTRL);
    chk(d[1:0], 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(4'(i));
      w[8*i +: 8] = d[7:0];
    end
    chk(w - v <= 32'd1, 32'h1);
    rd(IDX_IRQ_STATUS);
    chk(d, 32'h6);
    rd(IDX_IRQ_STATUS);
    chk(d, 32'h0);
    chk(irq, 32'h0);
    $display("Test transfers done");
    // Alarm three ticks ahead, written while disabled
    v = w + 32'd3;
    for (int i = 0; i < 4; i++) wr(4'(i + 8), v[8*i +: 8]);
    for (int i = 8; i < 12; i++) rdm(4'(i));
    chk(alarm_match, 32'h0);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CTRL, 8'h04);
    for (int k = 0; k < 6000 && alarm_match !== 1'b1; k++) @(posedge clock);
    chk(alarm_match, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 32'h1);
    rd(IDX_IRQ_STATUS);
    chk(d[0], 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 32'h0);
    $display("Test alarm done");
    wr(4'hC, 8'h5A);
    rd(4'hC);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    $display("Test unmapped done");
    give_verdict;
  end
endmodule
